// File: logic/timer16_counter_and_capture.v
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_consts.vh"
module timer16_counter_and_capture #(
	parameter WIDTH = 16
) (
	input wire i_sys_clk,
	input wire i_rst,
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	output reg [31:0] o_readdata,
	output wire o_waitrequest,
	input wire [7:1] i_prescale_ticks,
	input wire i_external_count_pin,
	input wire i_capture_pin,
	input wire i_comparator_output,
	input wire i_count_up,
	input wire i_count_clear,
	input wire i_top_reached,
	input wire i_bottom_reached,
	input wire i_overflow_event,
	input wire i_overflow_ack,
	input wire i_capture_ack,
	output wire [WIDTH-1:0] o_timer_count,
	output wire [WIDTH-1:0] o_capture_value,
	output wire [3:0] o_waveform_mode_field,
	output wire o_timer_tick,
	output wire o_overflow_irq,
	output wire o_capture_irq
);
// ==========================================
// Registers
reg [7:0] timer_control_a;
reg [7:0] timer_control_b;
reg [7:0] irq_enable;
reg comparator_capture_select;
reg [WIDTH-1:0] timer_count;
reg [WIDTH-1:0] capture_value;
reg [7:0] shared_latch;
reg overflow_flag;
reg capture_flag;
reg read_done;
wire [2:0] raw_in;
wire [2:0] synced;
wire [7:0] flag_clear;
genvar gi;
reg ext_prev;
reg src_prev;
reg [`NOISE_DEPTH-1:0] filter_taps;
reg filter_out;
reg edge_prev;
wire [2:0] clock_select_field;
wire [3:0] waveform_mode_field;
wire noise_filter_enable;
wire edge_rising;
wire bus_wr;
wire bus_rd;
wire [7:0] wbyte;
wire cap_is_top;
wire trig_src;
wire edge_in;
wire capture_event;
reg timer_tick;
reg [7:0] next_rdata;
assign waveform_mode_field = {timer_control_b[`CTRLB_WGM_HI_LSB+1:`CTRLB_WGM_HI_LSB], timer_control_a[1:0]};
assign clock_select_field = timer_control_b[`CTRLB_CS_LSB+2:`CTRLB_CS_LSB];
assign noise_filter_enable = timer_control_b[`CTRLB_NOISE_BIT];
assign edge_rising = timer_control_b[`CTRLB_EDGE_BIT];
// Reads hold one wait state while the data flop loads
assign o_waitrequest = i_read & ~read_done;
assign bus_wr = i_write & i_byteenable[0];
// First cycle of a read: latch copy and data capture happen here
assign bus_rd = i_read & ~read_done;
assign flag_clear = (bus_wr && i_address == `ADDR_FLAGS) ? wbyte : 8'h00;
assign wbyte = i_writedata[7:0];
// ==========================================
// Capture-as-top decode
function is_cap_top;
	input [3:0] mode;
	begin
		is_cap_top = (mode == 4'h8) | (mode == 4'ha) | (mode == 4'hc) | (mode == 4'he);
	end
endfunction
assign cap_is_top = is_cap_top(waveform_mode_field);
// ==========================================
// Tick select
// tick source select
always @* begin
	case (clock_select_field)
		3'h0: begin
			timer_tick = 1'b0;
		end
		3'h6: begin
			// Falling edge of the external count pin
			timer_tick = ext_prev & ~synced[0];
		end
		3'h7: begin
			timer_tick = ~ext_prev & synced[0];
		end
		default: begin
			timer_tick = i_prescale_ticks[clock_select_field];
		end
	endcase
end
// ==========================================
// Synchronisers and edge detection
// Raw levels are asynchronous, so each passes two flops first
assign raw_in = {i_comparator_output, i_capture_pin, i_external_count_pin};
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
		reg [`SYNC_STAGES-1:0] chain;
		always @(posedge i_sys_clk) begin
			if (i_rst) begin
				chain <= {`SYNC_STAGES{1'b0}};
			end else begin
				chain <= {chain[`SYNC_STAGES-2:0], raw_in[gi]};
			end
		end
		assign synced[gi] = chain[`SYNC_STAGES-1];
	end
endgenerate
// External count pin edge memory
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		ext_prev <= 1'b0;
	end else begin
		ext_prev <= synced[0];
	end
end
assign trig_src = comparator_capture_select ? synced[2] : synced[1];
// ==========================================
// Noise filter and edge detector
// four-sample agreement
// Taps fed beside the edge stage, so the filter costs exactly four clocks
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		src_prev <= 1'b0;
		filter_taps <= {`NOISE_DEPTH{1'b0}};
		filter_out <= 1'b0;
	end else if (!cap_is_top) begin
		src_prev <= trig_src;
		filter_taps <= {filter_taps[`NOISE_DEPTH-2:0], trig_src};
		if (&filter_taps) begin
			filter_out <= 1'b1;
		end else if (~|filter_taps) begin
			filter_out <= 1'b0;
		end
	end
end
assign edge_in = noise_filter_enable ? filter_out : src_prev;
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		edge_prev <= 1'b0;
	end else if (!cap_is_top) begin
		edge_prev <= edge_in;
	end
end
assign capture_event = !cap_is_top & (edge_rising ? (edge_in & ~edge_prev) : (~edge_in & edge_prev));
// ==========================================
// Address strobes
wire wr_cnt_lo;
wire wr_cap_lo;
wire wr_high;
wire rd_cnt_lo;
wire rd_cap_lo;
assign wr_cnt_lo = bus_wr && i_address == `ADDR_CNT_LO;
assign wr_cap_lo = bus_wr && i_address == `ADDR_CAP_LO;
assign wr_high = bus_wr && (i_address == `ADDR_CNT_HI || i_address == `ADDR_CAP_HI);
assign rd_cnt_lo = bus_rd && i_address == `ADDR_CNT_LO;
assign rd_cap_lo = bus_rd && i_address == `ADDR_CAP_LO;
// ==========================================
// Control registers
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		timer_control_a <= 8'h00;
		timer_control_b <= 8'h00;
		irq_enable <= 8'h00;
		comparator_capture_select <= 1'b0;
	end else if (bus_wr) begin
		case (i_address)
			`ADDR_CTRL_A: begin
				timer_control_a <= wbyte;
			end
			`ADDR_CTRL_B: begin
				timer_control_b <= wbyte;
			end
			`ADDR_IRQ_EN: begin
				irq_enable <= wbyte;
			end
			`ADDR_CMP_CTRL: begin
				comparator_capture_select <= wbyte[`CMP_SEL_BIT];
			end
			default: begin
			end
		endcase
	end
end
// ==========================================
// Counter
// Clear and direction come from the mode logic outside
// CPU write wins
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		timer_count <= {WIDTH{1'b0}};
	end else if (wr_cnt_lo) begin
		timer_count <= {shared_latch, wbyte};
	end else if (timer_tick) begin
		if (i_count_clear) begin
			timer_count <= {WIDTH{1'b0}};
		end else if (i_count_up) begin
			timer_count <= timer_count + 1'b1;
		end else begin
			timer_count <= timer_count - 1'b1;
		end
	end
end
// ==========================================
// Capture register
// Events are masked in top modes, so capture and write never meet
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		capture_value <= {WIDTH{1'b0}};
	end else if (capture_event) begin
		capture_value <= timer_count;
	end else if (wr_cap_lo && cap_is_top) begin
		capture_value <= {shared_latch, wbyte};
	end
end
// ==========================================
// Shared high-byte latch
// One latch serves both registers; interleaved 16-bit accesses clobber it
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		shared_latch <= 8'h00;
	end else if (rd_cnt_lo) begin
		shared_latch <= timer_count[WIDTH-1:WIDTH-8];
	end else if (rd_cap_lo) begin
		shared_latch <= capture_value[WIDTH-1:WIDTH-8];
	end else if (wr_high) begin
		shared_latch <= wbyte;
	end
end
// ==========================================
// Interrupt flags; a set in the clear cycle wins so no event is lost
// overflow flag
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		overflow_flag <= 1'b0;
	end else if (timer_tick && i_overflow_event) begin
		overflow_flag <= 1'b1;
	end else if (i_overflow_ack || flag_clear[`FLAG_OVF_BIT]) begin
		overflow_flag <= 1'b0;
	end
end
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		capture_flag <= 1'b0;
	end else if (capture_event) begin
		capture_flag <= 1'b1;
	end else if (i_capture_ack || flag_clear[`FLAG_CAP_BIT]) begin
		capture_flag <= 1'b0;
	end
end
// ==========================================
// Read handshake
// Registered read data costs one wait state per read
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		read_done <= 1'b0;
	end else begin
		read_done <= i_read & ~read_done;
	end
end
// ==========================================
// Read data
always @* begin
	case (i_address)
		`ADDR_CTRL_A: begin
			next_rdata = timer_control_a;
		end
		`ADDR_CTRL_B: begin
			next_rdata = timer_control_b;
		end
		`ADDR_CNT_LO: begin
			next_rdata = timer_count[7:0];
		end
		`ADDR_CNT_HI: begin
			next_rdata = shared_latch;
		end
		`ADDR_CAP_LO: begin
			next_rdata = capture_value[7:0];
		end
		`ADDR_CAP_HI: begin
			next_rdata = shared_latch;
		end
		`ADDR_FLAGS: begin
			next_rdata = {2'h0, capture_flag, 4'h0, overflow_flag};
		end
		`ADDR_IRQ_EN: begin
			next_rdata = irq_enable;
		end
		`ADDR_CMP_CTRL: begin
			next_rdata = {5'h00, comparator_capture_select, 2'h0};
		end
		default: begin
			next_rdata = 8'h00;
		end
	endcase
end
// Loaded on the first read cycle, so it stands when waitrequest drops
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		o_readdata <= 32'h00000000;
	end else if (bus_rd) begin
		o_readdata <= {24'h000000, next_rdata};
	end
end
// ==========================================
// Outputs
assign o_timer_count = timer_count;
assign o_capture_value = capture_value;
assign o_waveform_mode_field = waveform_mode_field;
assign o_timer_tick = timer_tick;
assign o_overflow_irq = overflow_flag & irq_enable[`FLAG_OVF_BIT];
assign o_capture_irq = capture_flag & irq_enable[`FLAG_CAP_BIT];
endmodule // timer16_counter_and_capture
`default_nettype wire

// File: logic/timer16_consts.vh
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH
// ==========================================
// Register word offsets (one data word per register)
`define ADDR_CTRL_A 4'h0
`define ADDR_CTRL_B 4'h1
`define ADDR_CNT_LO 4'h2
`define ADDR_CNT_HI 4'h3
`define ADDR_CAP_LO 4'h4
`define ADDR_CAP_HI 4'h5
`define ADDR_FLAGS 4'h6
`define ADDR_IRQ_EN 4'h7
`define ADDR_CMP_CTRL 4'h8
// ==========================================
// Field positions
`define CTRLB_NOISE_BIT 7
`define CTRLB_EDGE_BIT 6
`define CTRLB_WGM_HI_LSB 3
`define CTRLB_CS_LSB 0
`define FLAG_OVF_BIT 0
`define FLAG_CAP_BIT 5
`define CMP_SEL_BIT 2
// ==========================================
// Timing
`define NOISE_DEPTH 4
`define SYNC_STAGES 2
`endif

// File: test/timer16_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Counter and capture checker
module timer16_asserts #(
	parameter WIDTH = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_address,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic [7:1] i_prescale_ticks,
	input wire logic i_count_up,
	input wire logic i_count_clear,
	input wire logic i_capture_ack,
	input wire logic [WIDTH-1:0] o_timer_count,
	input wire logic [WIDTH-1:0] o_capture_value,
	input wire logic o_timer_tick,
	input wire logic o_capture_irq
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	logic [2:0] cs;
	logic cap_en;
	wire wr = i_write && i_byteenable[0];
	wire cnt_wr = wr && i_address == 4'h2;
	wire cap_wr = wr && i_address == 4'h4;
	// Shadow of the select and enable bits
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			cs <= 3'h0;
			cap_en <= 1'b0;
		end else if (wr && i_address == 4'h1) begin
			cs <= i_writedata[2:0];
		end else if (wr && i_address == 4'h7) begin
			cap_en <= i_writedata[5];
		end
	end
	AST_STOP: assert property (cs == 3'h0 |-> !o_timer_tick) else $error("tick while stopped");
	AST_SRC: assert property (cs != 3'h0 && cs < 3'h6 |-> o_timer_tick == i_prescale_ticks[cs])
		else $error("tick not from selected source");
	AST_WR: assert property (cnt_wr |=> o_timer_count[7:0] == $past(i_writedata[7:0]))
		else $error("count write lost");
	AST_HOLD: assert property (!o_timer_tick && !cnt_wr |=> $stable(o_timer_count)) else $error("count moved");
	AST_STEP: assert property (o_timer_tick && !cnt_wr && !i_count_clear
		|=> o_timer_count == WIDTH'($past(o_timer_count) + ($past(i_count_up) ? 1 : -1))) else $error("bad step");
	AST_CAP: assert property (o_capture_value != $past(o_capture_value) && !$past(cap_wr)
		|-> o_capture_value == $past(o_timer_count)) else $error("capture not counter");
	AST_IRQ: assert property (o_capture_value != $past(o_capture_value) && !$past(cap_wr) && cap_en
		|-> o_capture_irq) else $error("flag not set with capture");
	AST_ACK: assert property ($past(i_capture_ack) && $stable(o_capture_value) |-> !o_capture_irq)
		else $error("ack did not clear");
endmodule // timer16_asserts
bind timer16_counter_and_capture timer16_asserts #(.WIDTH(WIDTH)) u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_address(i_address), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
	.i_prescale_ticks(i_prescale_ticks), .i_count_up(i_count_up), .i_count_clear(i_count_clear),
	.i_capture_ack(i_capture_ack), .o_timer_count(o_timer_count), .o_capture_value(o_capture_value),
	.o_timer_tick(o_timer_tick), .o_capture_irq(o_capture_irq));
`default_nettype wire

// File: test/event_source.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// External event lines, push-pull so levels hold
module event_source (
	input wire logic i_sys_clk,
	input wire logic i_pin_req,
	input wire logic i_cmp_req,
	output logic o_capture_pin,
	output logic o_comparator_output
);
	initial begin
		o_capture_pin = 1'b0;
		o_comparator_output = 1'b0;
	end
	always @(posedge i_sys_clk) begin
		if (i_pin_req) o_capture_pin <= ~o_capture_pin;
		if (i_cmp_req) o_comparator_output <= ~o_comparator_output;
	end
endmodule // event_source
`default_nettype wire

// File: test/test_timer16_counter_and_capture.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bus tasks and scenarios
module test_timer16_counter_and_capture;
	logic i_sys_clk = 0, i_rst = 1, i_read = 0, i_write = 0, cu = 1, clr = 0, ack = 0, preq = 0, creq = 0;
	logic [3:0] i_address = 0, be = 4'hf;
	logic [31:0] i_writedata = 0;
	logic [15:0] last_rd = 0;
	logic ovf = 0;
	wire oirq;
	wire [3:0] wmode;
	logic [7:1] ticks = 0;
	wire [31:0] rdata;
	wire [15:0] cnt, cap;
	wire wreq, pin, cmp, cirq;
	int errors = 0, checked = 0;
	always #10 i_sys_clk = ~i_sys_clk;
	event_source src (.i_sys_clk(i_sys_clk), .i_pin_req(preq), .i_cmp_req(creq), .o_capture_pin(pin),
		.o_comparator_output(cmp));
	timer16_counter_and_capture dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(be), .o_readdata(rdata),
		.o_waitrequest(wreq), .i_prescale_ticks(ticks), .i_external_count_pin(1'b0), .i_capture_pin(pin),
		.i_comparator_output(cmp), .i_count_up(cu), .i_count_clear(clr), .i_top_reached(1'b0),
		.i_bottom_reached(1'b0), .i_overflow_event(ovf), .i_overflow_ack(1'b0), .i_capture_ack(ack),
		.o_timer_count(cnt), .o_capture_value(cap), .o_waveform_mode_field(wmode), .o_timer_tick(),
		.o_overflow_irq(oirq), .o_capture_irq(cirq));
	task automatic stop_test;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_address <= a;
		i_writedata <= {24'h0, d};
		i_write <= w;
		i_read <= ~w;
		do @(posedge i_sys_clk); while (wreq !== 1'b0);
		last_rd = rdata[15:0];
		i_write <= 0;
		i_read <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		acc(0, a, 0);
		chk("readdata", {8'h0, e}, last_rd);
	endtask
	task automatic tk(input int n);
		repeat (n) begin
			ticks <= 7'h01;
			@(posedge i_sys_clk);
			ticks <= 0;
			@(posedge i_sys_clk);
		end
	endtask
	task automatic ev(input logic c, input int n, input logic e);
		@(posedge i_sys_clk);
		if (c) creq <= 1;
		else preq <= 1;
		repeat (n) @(posedge i_sys_clk);
		creq <= 0;
		preq <= 0;
		repeat (20) @(posedge i_sys_clk);
		chk("capture_irq", e, cirq);
	endtask
	initial begin
		#300000;
		errors++;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 0;
		acc(1, 4'h3, 8'h12);
		acc(1, 4'h2, 8'h34);
		acc(1, 4'h3, 8'h56);
		tk(1);
		chk("count", 16'h1234, cnt);
		rd(4'h3, 8'h56);
		rd(4'h2, 8'h34);
		rd(4'h3, 8'h12);
		be <= 0;
		acc(1, 4'h2, 8'h77);
		be <= 4'hf;
		acc(1, 4'h1, 8'h01);
		tk(3);
		cu <= 0;
		tk(1);
		chk("count", 16'h1236, cnt);
		acc(1, 4'h7, 8'h01);
		ovf <= 1;
		tk(1);
		ovf <= 0;
		chk("overflow_irq", 1, oirq);
		acc(1, 4'h6, 8'h01);
		@(posedge i_sys_clk);
		chk("overflow_irq", 0, oirq);
		ticks <= 7'h01;
		acc(1, 4'h2, 8'h9a);
		ticks <= 0;
		@(posedge i_sys_clk);
		chk("count", 16'h129a, cnt);
		clr <= 1;
		tk(1);
		clr <= 0;
		chk("count", 16'h0000, cnt);
		acc(1, 4'h3, 8'hab);
		acc(1, 4'h2, 8'hcd);
		acc(1, 4'h1, 8'h40);
		acc(1, 4'h7, 8'h20);
		ev(0, 1, 1);
		chk("capture", 16'habcd, cap);
		rd(4'h4, 8'hcd);
		rd(4'h5, 8'hab);
		acc(1, 4'h6, 8'h20);
		@(posedge i_sys_clk);
		chk("capture_irq", 0, cirq);
		acc(1, 4'h1, 8'h00);
		acc(1, 4'h2, 8'h11);
		ev(0, 1, 1);
		chk("capture", 16'hab11, cap);
		ack <= 1;
		@(posedge i_sys_clk);
		ack <= 0;
		@(posedge i_sys_clk);
		chk("capture_irq", 0, cirq);
		acc(1, 4'h1, 8'hc0);
		ev(0, 2, 0);
		ev(0, 2, 0);
		ev(0, 1, 1);
		acc(1, 4'h8, 8'h04);
		acc(1, 4'h6, 8'h20);
		ev(1, 1, 1);
		acc(1, 4'h4, 8'h99);
		@(posedge i_sys_clk);
		chk("capture", 16'hab11, cap);
		acc(1, 4'h1, 8'h18);
		acc(1, 4'h5, 8'h77);
		chk("mode", 16'h000c, {12'h000, wmode});
		acc(1, 4'h4, 8'h99);
		acc(1, 4'h6, 8'h20);
		ev(1, 1, 0);
		chk("capture", 16'h7799, cap);
		stop_test;
	end
endmodule // test_timer16_counter_and_capture
`default_nettype wire
